/* File: lq_gpio_params.svh */
`ifndef LQ_GPIO_PARAMS_SVH
`define LQ_GPIO_PARAMS_SVH
`define FRM_START 8'hfe
`define FRM_END 8'hff
`define PORT_LQ 8'h23
`define PORT_ERR 8'h22
`define PORT_OUT_A 8'h44
`define PORT_OUT_B 8'h45
`define PORT_HOST_MIN 8'h80
`define ADDR_LOCAL 16'h0000
`define CMD_HIGH 8'h11
`define CMD_LOW 8'h10
`define CMD_READ 8'h12
`define LVL_HIGH 8'h01
`define LVL_LOW 8'h00
`define ERR_BAD_PORT 8'he0
`define QUAL_NO_REPLY 8'h80
`define BAUD_CODE_DEFAULT 8'h08
`define HDR_BYTES 8'h04
`define HDR_IDX_SRC 8'h00
`define HDR_IDX_DST 8'h01
`define HDR_IDX_ALO 8'h02
`define HDR_IDX_AHI 8'h03
`define PAY_MAX 8'h03
`define LQ_PAY_LEN 8'h02
`define OUT_PAY_LEN 8'h01
`define STRAP_SETTLE 2'h3
`define TX_FIXED 4'h6
`endif

/* File: lq_gpio_pkg.sv */
package lq_gpio_pkg;
  typedef enum {ST_IDLE, ST_LEN, ST_HDR, ST_END, ST_EXEC, ST_MEAS_REQ, ST_MEAS_WAIT,
    ST_SEND} cmd_state_t;
  typedef logic [7:0] byte_t;
endpackage

/* File: frame_tx_if.sv */
`timescale 1ns/100ps
interface frame_tx_if;
  import lq_gpio_pkg::*;
  logic start;
  logic busy;
  byte_t src;
  byte_t dst;
  logic [15:0] addr;
  byte_t pay0;
  byte_t pay1;
  byte_t pay2;
  logic [1:0] npay;
  modport ctl (output start, src, dst, addr, pay0, pay1, pay2, npay, input busy);
  modport tx (input start, src, dst, addr, pay0, pay1, pay2, npay, output busy);
endinterface

/* File: frame_tx.sv */
`timescale 1ns/100ps
`include "lq_gpio_params.svh"
module frame_tx
  import lq_gpio_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  frame_tx_if.tx f,
  output logic tx_valid,
  input wire logic tx_ready,
  output byte_t tx_data
);
  logic busy_q;
  logic [3:0] idx_q;
  byte_t data_q;
  logic [3:0] last;

  // Picks the byte of the frame at a given position; the closing position gives the end byte.
  function automatic byte_t byte_at(input logic [3:0] i);
    byte_t b;
    b = `FRM_END;
    if (i != last) begin
      case (i)
        4'h0: b = `FRM_START;
        4'h1: b = `HDR_BYTES + {6'h00, f.npay};
        4'h2: b = f.src;
        4'h3: b = f.dst;
        4'h4: b = f.addr[7:0];
        4'h5: b = f.addr[15:8];
        `TX_FIXED: b = f.pay0;
        `TX_FIXED + 4'h1: b = f.pay1;
        `TX_FIXED + 4'h2: b = f.pay2;
        default: b = `FRM_END;
      endcase
    end
    return b;
  endfunction

  // Position of the closing byte: the fixed header, then up to three payload bytes.
  assign last = `TX_FIXED + {2'h0, f.npay};

  // Walks the frame one byte per accepted beat.
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      idx_q <= 4'h0;
      data_q <= 8'h00;
    end else if (!busy_q && f.start) begin
      busy_q <= 1'b1;
      idx_q <= 4'h0;
      data_q <= `FRM_START;
    end else if (busy_q && tx_ready) begin
      if (idx_q == last) begin
        busy_q <= 1'b0;
      end else begin
        idx_q <= idx_q + 4'h1;
        data_q <= byte_at(idx_q + 4'h1);
      end
    end
  end

  assign f.busy = busy_q;
  assign tx_valid = busy_q;
  assign tx_data = data_q;

  // Every frame opens with the start delimiter.
  AST_TX_START: assert property (@(posedge clk) disable iff (rst)
    !busy_q && f.start |=> tx_valid && tx_data == `FRM_START)
    else $error("frame does not open with start byte");
  // Data stays still while the sink stalls.
  AST_TX_HOLD: assert property (@(posedge clk) disable iff (rst)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx data changed while stalled");
endmodule

/* File: lq_gpio_cmd.sv */
`timescale 1ns/100ps
`include "lq_gpio_params.svh"
// Functional notes
// - Port 0x23 measures two-way link quality from averaged signal strengths.
// - Request frame: ports 80 then 23, node address, target address, delimiters.
// - A request radios a measure command; the target answers with its strength.
// - Reply combines both readings: target address then one quality byte.
// - Quality is signed, higher is better; 0x80 means no reply came.
// - Remote requests are measured too and answered back to the requester.
// - Measurement runs whether or not a route to the target exists.
// - Port 0x44 drives the first spare pin, 0x45 the second.
// - Byte 0x11 drives the pin high, 0x10 low, on receipt.
// - Byte 0x12 leaves the pin and returns a level report.
// - Level report is 0x01 for high and 0x00 for low.
// - Under the forced rate, reads return the stored setting; writes allowed.
// - A restart without a new setting resumes the stored rate.
// - Test strap grounded puts test serial traffic on the spare pins.
// - Ports 0x44/0x45 answer only to node address 0x0000; port 0x23 also to the node's own address.
// - Host source port below 0x80 draws an error frame from port 0x22.
module lq_gpio_cmd
  import lq_gpio_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic RX_VALID,
  input wire byte_t RX_DATA,
  output logic RX_READY,
  output logic TX_VALID,
  input wire logic TX_READY,
  output byte_t TX_DATA,
  input wire logic [15:0] LOCAL_ADDR,
  output logic MEAS_REQ,
  output logic [15:0] MEAS_TARGET,
  input wire logic MEAS_DONE,
  input wire logic MEAS_REPLIED,
  input wire byte_t LOCAL_RSSI,
  input wire byte_t PEER_RSSI,
  input wire logic REMOTE_REQ,
  input wire logic [15:0] REMOTE_FROM,
  input wire logic [15:0] REMOTE_TARGET,
  output logic REMOTE_READY,
  output logic RESULT_VALID,
  output logic [15:0] RESULT_NODE,
  output logic [15:0] RESULT_TARGET,
  output byte_t RESULT_QUALITY,
  input wire logic BAUD_DEFAULT_STRAP_N,
  input wire logic TEST_MODE_STRAP_N,
  input wire byte_t STORED_BAUD,
  output byte_t BAUD_SEL,
  output byte_t BAUD_READBACK,
  input wire logic TEST_SER_A,
  input wire logic TEST_SER_B,
  output logic SPARE_OUT_A,
  output logic SPARE_OUT_B
);
  // ****************************************
  // Strap capture
  // ****************************************
  logic [1:0] baud_sync_q;
  logic [1:0] test_sync_q;
  logic [1:0] settle_q;
  logic force_baud_q;
  logic test_mode_q;

  // Pin straps pass two flops, then are held once after reset settles.
  always_ff @(posedge CLK) begin
    if (RST) begin
      baud_sync_q <= 2'h3;
      test_sync_q <= 2'h3;
      settle_q <= 2'h0;
      force_baud_q <= 1'b0;
      test_mode_q <= 1'b0;
    end else begin
      baud_sync_q <= {baud_sync_q[0], BAUD_DEFAULT_STRAP_N};
      test_sync_q <= {test_sync_q[0], TEST_MODE_STRAP_N};
      if (settle_q != `STRAP_SETTLE) begin
        settle_q <= settle_q + 2'h1;
        force_baud_q <= !baud_sync_q[1];
        test_mode_q <= !test_sync_q[1];
      end
    end
  end

  // The forced rate steers the line only; reads always see the stored code.
  assign BAUD_SEL = force_baud_q ? `BAUD_CODE_DEFAULT : STORED_BAUD;
  assign BAUD_READBACK = STORED_BAUD;

  // ****************************************
  // Frame parser and dispatcher
  // ****************************************
  cmd_state_t state_q;
  byte_t len_q;
  byte_t idx_q;
  byte_t src_q;
  byte_t dst_q;
  logic [15:0] addr_q;
  byte_t pay_q [3];
  logic remote_q;
  logic [15:0] from_q;
  logic [15:0] target_q;
  logic lvl_a_q;
  logic lvl_b_q;
  byte_t quality;
  logic [8:0] rssi_sum;
  logic rx_take;
  logic tx_sent_q;
  logic [1:0] npay;
  frame_tx_if txf ();

  assign rx_take = RX_VALID && RX_READY;
  assign RX_READY = state_q == ST_IDLE || state_q == ST_LEN || state_q == ST_HDR
    || state_q == ST_END;
  assign REMOTE_READY = state_q == ST_IDLE && !RX_VALID;
  assign npay = (len_q > `HDR_BYTES + `PAY_MAX) ? 2'h3 : 2'(len_q - `HDR_BYTES);

  // Quality is the signed mean of both strengths, or the no-reply mark.
  assign rssi_sum = {LOCAL_RSSI[7], LOCAL_RSSI} + {PEER_RSSI[7], PEER_RSSI};
  assign quality = MEAS_REPLIED ? rssi_sum[8:1] : `QUAL_NO_REPLY;

  // Main sequence: collect a frame, act on it, answer it.
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      len_q <= 8'h00;
      idx_q <= 8'h00;
      src_q <= 8'h00;
      dst_q <= 8'h00;
      addr_q <= 16'h0000;
      pay_q <= '{8'h00, 8'h00, 8'h00};
      remote_q <= 1'b0;
      from_q <= 16'h0000;
      target_q <= 16'h0000;
      tx_sent_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (rx_take && RX_DATA == `FRM_START) begin
            state_q <= ST_LEN;
          end else if (REMOTE_REQ && REMOTE_READY) begin
            remote_q <= 1'b1;
            from_q <= REMOTE_FROM;
            target_q <= REMOTE_TARGET;
            state_q <= ST_MEAS_REQ;
          end
        end
        ST_LEN: begin
          if (rx_take) begin
            len_q <= RX_DATA;
            idx_q <= 8'h00;
            state_q <= (RX_DATA < `HDR_BYTES) ? ST_IDLE : ST_HDR;
          end
        end
        ST_HDR: begin
          if (rx_take) begin
            case (idx_q)
              `HDR_IDX_SRC: src_q <= RX_DATA;
              `HDR_IDX_DST: dst_q <= RX_DATA;
              `HDR_IDX_ALO: addr_q[7:0] <= RX_DATA;
              `HDR_IDX_AHI: addr_q[15:8] <= RX_DATA;
              default: begin
                if (idx_q - `HDR_BYTES < `PAY_MAX) pay_q[2'(idx_q - `HDR_BYTES)] <= RX_DATA;
              end
            endcase
            idx_q <= idx_q + 8'h01;
            if (idx_q == len_q - 8'h01) state_q <= ST_END;
          end
        end
        ST_END: begin
          if (rx_take) state_q <= (RX_DATA == `FRM_END) ? ST_EXEC : ST_IDLE;
        end
        ST_EXEC: begin
          state_q <= ST_IDLE;
          if (src_q < `PORT_HOST_MIN) begin
            state_q <= ST_SEND;
          end else if (dst_q == `PORT_LQ && len_q == `HDR_BYTES + `LQ_PAY_LEN
              && (addr_q == `ADDR_LOCAL || addr_q == LOCAL_ADDR)) begin
            remote_q <= 1'b0;
            target_q <= {pay_q[1], pay_q[0]};
            state_q <= ST_MEAS_REQ;
          end else if ((dst_q == `PORT_OUT_A || dst_q == `PORT_OUT_B)
              && addr_q == `ADDR_LOCAL && len_q == `HDR_BYTES + `OUT_PAY_LEN
              && pay_q[0] == `CMD_READ) begin
            state_q <= ST_SEND;
          end
        end
        ST_MEAS_REQ: state_q <= ST_MEAS_WAIT;
        ST_MEAS_WAIT: begin
          if (MEAS_DONE) state_q <= remote_q ? ST_IDLE : ST_SEND;
          if (MEAS_DONE) pay_q[2] <= quality;
        end
        // Holds the reply fields steady until the whole frame has left.
        ST_SEND: begin
          if (txf.start) tx_sent_q <= 1'b1;
          if (tx_sent_q && !txf.busy) begin
            tx_sent_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Radio request pulses once per measurement, no route check needed.
  assign MEAS_REQ = state_q == ST_MEAS_REQ;
  assign MEAS_TARGET = target_q;

  // Result for a remote requester goes out on the radio side.
  always_ff @(posedge CLK) begin
    if (RST) begin
      RESULT_VALID <= 1'b0;
      RESULT_NODE <= 16'h0000;
      RESULT_TARGET <= 16'h0000;
      RESULT_QUALITY <= 8'h00;
    end else begin
      RESULT_VALID <= state_q == ST_MEAS_WAIT && MEAS_DONE && remote_q;
      if (state_q == ST_MEAS_WAIT && MEAS_DONE) begin
        RESULT_NODE <= from_q;
        RESULT_TARGET <= target_q;
        RESULT_QUALITY <= quality;
      end
    end
  end

  // ****************************************
  // Spare outputs
  // ****************************************
  // Level commands land when the frame closes; other bytes are ignored.
  always_ff @(posedge CLK) begin
    if (RST) begin
      lvl_a_q <= 1'b0;
      lvl_b_q <= 1'b0;
    end else if (state_q == ST_EXEC && src_q >= `PORT_HOST_MIN && addr_q == `ADDR_LOCAL
        && len_q == `HDR_BYTES + `OUT_PAY_LEN) begin
      if (dst_q == `PORT_OUT_A && pay_q[0] == `CMD_HIGH) lvl_a_q <= 1'b1;
      if (dst_q == `PORT_OUT_A && pay_q[0] == `CMD_LOW) lvl_a_q <= 1'b0;
      if (dst_q == `PORT_OUT_B && pay_q[0] == `CMD_HIGH) lvl_b_q <= 1'b1;
      if (dst_q == `PORT_OUT_B && pay_q[0] == `CMD_LOW) lvl_b_q <= 1'b0;
    end
  end

  assign SPARE_OUT_A = test_mode_q ? TEST_SER_A : lvl_a_q;
  assign SPARE_OUT_B = test_mode_q ? TEST_SER_B : lvl_b_q;

  // ****************************************
  // Reply frame
  // ****************************************
  // Reply fields depend on which service answers.
  always_comb begin
    txf.start = state_q == ST_SEND && !tx_sent_q && !txf.busy;
    txf.src = dst_q;
    txf.dst = src_q;
    txf.addr = `ADDR_LOCAL;
    txf.pay0 = (dst_q == `PORT_OUT_A ? lvl_a_q : lvl_b_q) ? `LVL_HIGH : `LVL_LOW;
    txf.pay1 = 8'h00;
    txf.pay2 = 8'h00;
    txf.npay = 2'(`OUT_PAY_LEN);
    if (src_q < `PORT_HOST_MIN) begin
      txf.src = `PORT_ERR;
      txf.pay0 = `ERR_BAD_PORT;
      txf.pay1 = src_q;
      txf.npay = 2'(`LQ_PAY_LEN);
    end else if (dst_q == `PORT_LQ) begin
      txf.addr = LOCAL_ADDR;
      txf.pay0 = target_q[7:0];
      txf.pay1 = target_q[15:8];
      txf.pay2 = pay_q[2];
      txf.npay = 2'(`PAY_MAX);
    end
  end

  frame_tx u_tx (
    .clk(CLK),
    .rst(RST),
    .f(txf),
    .tx_valid(TX_VALID),
    .tx_ready(TX_READY),
    .tx_data(TX_DATA)
  );

  AST_NO_REPLY: assert property (@(posedge CLK) disable iff (RST)
    state_q == ST_MEAS_WAIT && MEAS_DONE && !MEAS_REPLIED |=> pay_q[2] == 8'h80)
    else $error("missing reply not marked 0x80");
  AST_MEAS_PULSE: assert property (@(posedge CLK) disable iff (RST)
    MEAS_REQ |=> !MEAS_REQ)
    else $error("measure request longer than one cycle");
  AST_REMOTE_RESULT: assert property (@(posedge CLK) disable iff (RST)
    state_q == ST_MEAS_WAIT && MEAS_DONE && remote_q |=> RESULT_VALID
      && RESULT_NODE == from_q)
    else $error("remote result not returned");
  AST_SET_HIGH: assert property (@(posedge CLK) disable iff (RST)
    state_q == ST_EXEC && src_q >= 8'h80 && dst_q == 8'h44 && addr_q == 16'h0000
      && len_q == 8'h05 && pay_q[0] == 8'h11 |=> lvl_a_q)
    else $error("first pin not set high");
  AST_READ_KEEPS: assert property (@(posedge CLK) disable iff (RST)
    state_q == ST_EXEC && pay_q[0] == 8'h12 |=> $stable(lvl_a_q) && $stable(lvl_b_q))
    else $error("read command changed a pin");
  AST_ERR_PORT: assert property (@(posedge CLK) disable iff (RST)
    txf.start && src_q < 8'h80 |-> txf.src == 8'h22 && txf.pay0 == 8'he0)
    else $error("bad source port not reported");
  AST_TEST_MODE: assert property (@(posedge CLK) disable iff (RST)
    test_mode_q |-> SPARE_OUT_B == TEST_SER_B)
    else $error("test traffic not on spare pin");
  AST_BAUD_FORCE: assert property (@(posedge CLK) disable iff (RST)
    force_baud_q |-> BAUD_SEL == 8'h08 && BAUD_READBACK == STORED_BAUD)
    else $error("forced baud wrong");
endmodule

/* File: host_model.sv */
`timescale 1ns/100ps
// ****************
// Host end of the UART byte stream.
// ****************
module host_model
  import lq_gpio_pkg::*;
(
  input wire logic clk,
  output logic rx_valid,
  output byte_t rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire byte_t tx_data,
  output logic tx_ready
);
  byte_t got[$];
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // Each byte stands until taken; the idle line then shows the inverse value.
  task automatic send(input byte_t f[$]);
    foreach (f[i]) begin
      rx_valid <= 1'b1;
      rx_data <= f[i];
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_data <= ~f[f.size()-1];
    @(posedge clk);
  endtask
  // Reply bytes are collected; when slow is set the host stalls every other cycle.
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
// ****************
// Self-checking bench for the command port.
// ****************
module testbench;
  import lq_gpio_pkg::*;
  logic clk, rst, rx_valid, rx_ready, tx_valid, tx_ready, meas_req, meas_done, meas_replied;
  logic remote_req, remote_ready, result_valid, baud_n, test_n, ser_a, ser_b, out_a, out_b;
  byte_t rx_data, tx_data, local_rssi, peer_rssi, result_quality, stored_baud, baud_sel, baud_rb;
  logic [15:0] meas_target, remote_from, remote_target, result_node, result_target;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  int peer_wait = 3;
  host_model host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  lq_gpio_cmd DUT (.CLK(clk), .RST(rst), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .LOCAL_ADDR(16'h0001), .MEAS_REQ(meas_req), .MEAS_TARGET(meas_target),
    .MEAS_DONE(meas_done), .MEAS_REPLIED(meas_replied), .LOCAL_RSSI(local_rssi),
    .PEER_RSSI(peer_rssi), .REMOTE_REQ(remote_req), .REMOTE_FROM(remote_from),
    .REMOTE_TARGET(remote_target), .REMOTE_READY(remote_ready), .RESULT_VALID(result_valid),
    .RESULT_NODE(result_node), .RESULT_TARGET(result_target), .RESULT_QUALITY(result_quality),
    .BAUD_DEFAULT_STRAP_N(baud_n), .TEST_MODE_STRAP_N(test_n), .STORED_BAUD(stored_baud),
    .BAUD_SEL(baud_sel), .BAUD_READBACK(baud_rb), .TEST_SER_A(ser_a), .TEST_SER_B(ser_b),
    .SPARE_OUT_A(out_a), .SPARE_OUT_B(out_b));
  // Clock of 20 ns period.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Peer radio answers a measure pulse after a settable delay.
  always @(posedge clk) begin
    if (meas_req === 1'b1) begin
      repeat (peer_wait) @(posedge clk);
      meas_done <= 1'b1;
      @(posedge clk);
      meas_done <= 1'b0;
    end
  end
  // Hang guard.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Waits for a whole reply frame and compares it byte by byte.
  task automatic expect_frame(input byte_t f[$]);
    int k;
    for (k = 0; k < 600 && host.got.size() < f.size(); k++) @(posedge clk);
    check(16'(host.got.size()), 16'(f.size()), "frame length");
    foreach (f[i]) if (i < host.got.size()) check(16'(host.got[i]), 16'(f[i]), "frame byte");
    host.got.delete();
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  function automatic byte_t qual(input byte_t l, input byte_t p, input logic rep);
    logic [8:0] s;
    s = {l[7], l} + {p[7], p};
    return rep ? s[8:1] : 8'h80;
  endfunction
  // Both spare pins: set, read back, unknown code and foreign address.
  task automatic t_outputs();
    byte_t p;
    for (int i = 0; i < 2; i++) begin
      p = 8'h44 + 8'(i);
      host.slow = i[0];
      host.send('{8'hfe, 8'h05, 8'h80, p, 8'h00, 8'h00, 8'h11, 8'hff});
      repeat (3) @(posedge clk);
      check(16'(i ? out_b : out_a), 16'h1, "pin high");
      host.send('{8'hfe, 8'h05, 8'h80, p, 8'h00, 8'h00, 8'h12, 8'hff});
      expect_frame('{8'hfe, 8'h05, p, 8'h80, 8'h00, 8'h00, 8'h01, 8'hff});
      host.send('{8'hfe, 8'h05, 8'h80, p, 8'h00, 8'h00, 8'h13, 8'hff});
      host.send('{8'hfe, 8'h05, 8'h80, p, 8'h05, 8'h00, 8'h10, 8'hff});
      repeat (8) @(posedge clk);
      check(16'(i ? out_b : out_a), 16'h1, "pin kept");
      check(16'(host.got.size()), 16'h0, "no reply");
      host.send('{8'hfe, 8'h05, 8'h80, p, 8'h00, 8'h00, 8'h10, 8'hff});
      repeat (3) @(posedge clk);
      check(16'(i ? out_b : out_a), 16'h0, "pin low");
      host.send('{8'hfe, 8'h05, 8'h80, p, 8'h00, 8'h00, 8'h12, 8'hff});
      expect_frame('{8'hfe, 8'h05, p, 8'h80, 8'h00, 8'h00, 8'h00, 8'hff});
    end
    host.slow = 1'b0;
  endtask
  // A source port below the host range draws an error report.
  task automatic t_error();
    host.send('{8'hfe, 8'h05, 8'h7f, 8'h44, 8'h00, 8'h00, 8'h11, 8'hff});
    expect_frame('{8'hfe, 8'h06, 8'h22, 8'h7f, 8'h00, 8'h00, 8'he0, 8'h7f, 8'hff});
    check(16'(out_a), 16'h0, "pin after error");
  endtask
  // Local measurement with a given peer answer.
  task automatic t_measure(input logic [15:0] t, input byte_t l, input byte_t p, input logic r);
    local_rssi <= l;
    peer_rssi <= p;
    meas_replied <= r;
    host.send('{8'hfe, 8'h06, 8'h80, 8'h23, 8'h00, 8'h00, t[7:0], t[15:8], 8'hff});
    expect_frame('{8'hfe, 8'h07, 8'h23, 8'h80, 8'h01, 8'h00, t[7:0], t[15:8], qual(l, p, r),
      8'hff});
    check(meas_target, t, "measure target");
  endtask
  // Remote request is measured and reported to the requester.
  task automatic t_remote();
    int k;
    peer_wait = 9;
    local_rssi <= 8'he0;
    peer_rssi <= 8'hd0;
    meas_replied <= 1'b1;
    for (k = 0; k < 50 && remote_ready !== 1'b1; k++) @(posedge clk);
    remote_from <= 16'h0033;
    remote_target <= 16'h0044;
    remote_req <= 1'b1;
    @(posedge clk);
    remote_req <= 1'b0;
    for (k = 0; k < 200 && result_valid !== 1'b1; k++) @(posedge clk);
    check(16'(result_valid), 16'h1, "result pulse");
    check(result_node, 16'h0033, "result node");
    check(result_target, 16'h0044, "result target");
    check(16'(result_quality), 16'(qual(8'he0, 8'hd0, 1'b1)), "result quality");
    peer_wait = 3;
  endtask
  // Power-up straps for baud default and test mode.
  task automatic t_straps();
    stored_baud <= 8'h02;
    baud_n <= 1'b0;
    do_reset();
    check(16'(baud_sel), 16'h08, "forced rate");
    check(16'(baud_rb), 16'h02, "readback");
    baud_n <= 1'b1;
    do_reset();
    check(16'(baud_sel), 16'h02, "stored rate");
    test_n <= 1'b0;
    do_reset();
    for (int i = 0; i < 2; i++) begin
      ser_a <= i[0];
      ser_b <= ~i[0];
      repeat (3) @(posedge clk);
      check(16'({out_a, out_b}), 16'({i[0], ~i[0]}), "test traffic");
    end
    test_n <= 1'b1;
    do_reset();
  endtask
  // Main sequence.
  initial begin
    rst = 1'b1;
    meas_done = 1'b0;
    meas_replied = 1'b0;
    local_rssi = 8'h00;
    peer_rssi = 8'h00;
    remote_req = 1'b0;
    remote_from = 16'h0000;
    remote_target = 16'h0000;
    baud_n = 1'b1;
    test_n = 1'b1;
    stored_baud = 8'h05;
    ser_a = 1'b0;
    ser_b = 1'b0;
    @(posedge clk);
    do_reset();
    t_outputs();
    t_error();
    t_measure(16'h0002, 8'h10, 8'h20, 1'b1);
    t_measure(16'h1234, 8'hf0, 8'h80, 1'b1);
    t_measure(16'h0302, 8'h30, 8'h30, 1'b0);
    t_remote();
    t_straps();
    give_verdict();
  end
endmodule
